// ===== dv/fcr_rewrite_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"
module fcr_rewrite_props (
    // clock and reset
    input wire logic                clock,
    input wire logic                rst,
    // register bus
    input wire logic                hsel,
    input wire logic [7:0]          haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    // sequencer
    input wire logic                seq_start,
    input wire logic [1:0]          seq_op,
    input wire fcr_pkg::fcr_block_t seq_block,
    input wire logic                seq_suspend,
    input wire logic                seq_done,
    // processor
    input wire logic                irq_pending,
    input wire logic                cpu_access,
    input wire fcr_pkg::fcr_block_t cpu_block,
    input wire logic                cpu_is_flash,
    input wire logic                cpu_wait,
    input wire logic                cpu_hold,
    input wire logic                flash_read_allow,
    input wire logic                read_status_mode
);
    import fcr_pkg::*;
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       ren, m1, dw, sen, gw, busy;
    // shadows of the control bits, mirrored from bus writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            wr_addr <= haddr;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {ren, m1, dw, sen, gw} <= 5'h00;
        end else if (wr_pend) begin
            case (wr_addr)
                `FCR_ADDR_CTRL0: ren <= hwdata[`FCR_C0_REWR_EN];
                `FCR_ADDR_CTRL1: {m1, dw} <= {hwdata[`FCR_C1_MODE1], hwdata[`FCR_C1_DATA_WAIT]};
                `FCR_ADDR_CTRL4: sen <= hwdata[`FCR_C4_SUSP_EN];
                `FCR_ADDR_MISC: gw <= hwdata[`FCR_MS_GEN_WAIT];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            busy <= 1'b0;
        else if (seq_start)
            busy <= 1'b1;
        else if (seq_done)
            busy <= 1'b0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_start_in_rom: assert property (
        seq_start |-> seq_block != FCR_BLK_X) else $error("start outside user rom");
    a_read_in_suspend: assert property (
        seq_suspend [*2] |-> flash_read_allow) else $error("flash unreadable in suspend");
    a_wait_rewrite: assert property (
        cpu_access && cpu_is_flash && ren |=> cpu_wait) else $error("no wait in rewrite");
    a_wait_data_block: assert property (
        cpu_access && cpu_is_flash && dw && cpu_block inside {FCR_BLK_A, FCR_BLK_B}
        |=> cpu_wait) else $error("no wait on data block");
    a_wait_ram_general: assert property (
        cpu_access && !cpu_is_flash |=> cpu_wait == gw) else $error("ram wait wrong");
    a_suspend_when_enabled: assert property (
        $rose(seq_suspend) |-> sen && busy && seq_op == `FCR_OP_ERASE)
        else $error("suspend without enabled erase");
    a_irq_suspends: assert property (
        busy && m1 && sen && seq_op == `FCR_OP_ERASE && irq_pending
        |-> ##[1:6] (seq_suspend || !busy)) else $error("interrupt did not suspend");
    a_mode_after_done: assert property (
        busy && seq_done && !seq_suspend |-> ##[1:2] read_status_mode == !m1)
        else $error("wrong read mode after done");
    a_hold_mode_one: assert property (
        seq_start |=> cpu_hold == m1) else $error("hold mismatch");
endmodule // fcr_rewrite_props
bind fcr_flash_cpu_rewrite_control fcr_rewrite_props fcr_rewrite_props_i (
    .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .seq_start,
    .seq_op, .seq_block, .seq_suspend, .seq_done, .irq_pending, .cpu_access,
    .cpu_block, .cpu_is_flash, .cpu_wait, .cpu_hold, .flash_read_allow, .read_status_mode
);
`default_nettype wire

// ===== dv/fcr_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcr_seq_model (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // sequencer side
    input wire logic       seq_start,
    input wire logic [1:0] seq_op,
    input wire logic       seq_suspend,
    input wire logic       fail,
    output var logic       seq_done,
    output var logic       seq_prog_fail,
    output var logic       seq_erase_fail
);
    logic [5:0] left;
    // erase is slow so a suspend can land mid-run; program answers quickly
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            left <= 6'h00;
            {seq_done, seq_prog_fail, seq_erase_fail} <= 3'h0;
        end else begin
            seq_done <= left == 6'h01 && !seq_suspend;
            seq_prog_fail <= fail && seq_op == 2'h1;
            seq_erase_fail <= fail && seq_op == 2'h2;
            if (seq_start)
                left <= (seq_op == 2'h2) ? 6'h28 : 6'h06;
            else if (left != 6'h00 && !seq_suspend)
                left <= left - 6'h01;
        end
    end
endmodule // fcr_seq_model
`default_nettype wire

// ===== dv/test_flash_cpu_rewrite_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"
module test_flash_cpu_rewrite_control;
    import fcr_pkg::*;
    logic        clock, rst, hsel, hwrite, hready, hreadyout, hresp, fail;
    logic [7:0]  haddr;
    logic [1:0]  htrans, seq_op;
    logic [31:0] hwdata, hrdata;
    logic        seq_start, seq_suspend, seq_done, seq_prog_fail, seq_erase_fail;
    logic        irq_pending, cpu_access, cpu_is_flash, cpu_wait, cpu_hold;
    logic        flash_read_allow, read_status_mode;
    fcr_block_t  seq_block, cpu_block;
    int          bad_count, n_compared, starts, cycles;
    assign hready = hreadyout;
    fcr_flash_cpu_rewrite_control fcr_flash_cpu_rewrite_control_i (
        .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .seq_start, .seq_op, .seq_block,
        .seq_suspend, .seq_done, .seq_prog_fail, .seq_erase_fail, .irq_pending,
        .cpu_access, .cpu_block, .cpu_is_flash, .cpu_wait, .cpu_hold,
        .flash_read_allow, .read_status_mode
    );
    fcr_seq_model fcr_seq_model_i (.clock, .rst, .seq_start, .seq_op, .seq_suspend,
        .fail, .seq_done, .seq_prog_fail, .seq_erase_fail);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        starts <= starts + ((seq_start === 1'b1) ? 1 : 0);
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clock); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0); // slave answers okay only
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(q & m, e);
    endtask
    task automatic wait_done;
        repeat (100) begin
            @(posedge clock);
            if (seq_done === 1'b1)
                break;
        end
        repeat (2) @(posedge clock);
    endtask
    // issue a command, then check whether it was started or refused
    task automatic cmd(input logic [2:0] blk, input logic [1:0] op, input logic ok);
        int s;
        s = starts;
        wr(`FCR_ADDR_CMD, {21'h0, blk, 6'h0, op});
        repeat (3) @(posedge clock);
        chk(starts, s + ok);
        rchk(`FCR_ADDR_MISC, 32'h4, ok ? 32'h0 : 32'h4);
        if (ok)
            wait_done();
    endtask
    task automatic acc(input fcr_block_t blk, input logic fl, input logic e);
        cpu_access   <= 1'b1;
        cpu_block    <= blk;
        cpu_is_flash <= fl;
        @(posedge clock);
        cpu_access   <= 1'b0;
        @(posedge clock);
        chk({31'h0, cpu_wait}, {31'h0, e});
    endtask
    initial begin
        {hsel, hwrite, irq_pending, cpu_access, cpu_is_flash, fail} = 6'h0;
        {haddr, htrans, hwdata} = 42'h0;
        cpu_block = FCR_BLK_0;
        {bad_count, n_compared, starts, cycles} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rchk(`FCR_ADDR_CTRL0, 32'h6, 32'h0);
        rchk(`FCR_ADDR_CTRL1, 32'h42, 32'h0);
        rchk(`FCR_ADDR_CTRL4, 32'h3, 32'h0);
        wr(8'h18, 32'hffffffff);
        rchk(8'h18, 32'hffffffff, 32'h0);
        wr(`FCR_ADDR_CTRL1, 32'h0);
        wr(`FCR_ADDR_CTRL1, 32'h40);
        rchk(`FCR_ADDR_CTRL1, 32'h40, 32'h0);
        wr(`FCR_ADDR_CTRL0, 32'h2);
        wr(`FCR_ADDR_CTRL1, 32'h40);
        rchk(`FCR_ADDR_CTRL1, 32'h40, 32'h0);
        wr(`FCR_ADDR_CTRL1, 32'h0);
        wr(`FCR_ADDR_CTRL1, 32'h40);
        rchk(`FCR_ADDR_CTRL1, 32'h40, 32'h40);
        for (int b = 0; b < 8; b++)
            cmd(b[2:0], `FCR_OP_PROGRAM, b >= 2 && b != 7);
        wr(`FCR_ADDR_CTRL0, 32'h6);
        cmd(3'h0, `FCR_OP_PROGRAM, 1'b1);
        cmd(3'h1, `FCR_OP_ERASE, 1'b1);
        chk({31'h0, read_status_mode}, 32'h1);
        fail <= 1'b1;
        cmd(3'h2, `FCR_OP_PROGRAM, 1'b1);
        fail <= 1'b0;
        rchk(`FCR_ADDR_CTRL0, 32'hc1, 32'h41);
        rchk(`FCR_ADDR_SEQSTAT, 32'hb0, 32'h90);
        // mode 1: control program pretends to live in block 3
        wr(`FCR_ADDR_CTRL1, 32'hc2);
        wr(`FCR_ADDR_MISC, 32'h300);
        cmd(3'h4, `FCR_OP_PROGRAM, 1'b1);
        chk({31'h0, read_status_mode}, 32'h0);
        cmd(3'h4, `FCR_OP_READ_STAT, 1'b0);
        cmd(3'h3, `FCR_OP_PROGRAM, 1'b0);
        wr(`FCR_ADDR_CTRL4, 32'h1);
        wr(`FCR_ADDR_CMD, {21'h0, 3'h5, 6'h0, `FCR_OP_ERASE});
        repeat (6) @(posedge clock);
        irq_pending <= 1'b1;
        repeat (8) @(posedge clock);
        chk({31'h0, seq_suspend}, 32'h1);
        chk({31'h0, flash_read_allow}, 32'h1);
        rchk(`FCR_ADDR_CTRL4, 32'h43, 32'h43);
        irq_pending <= 1'b0;
        wr(`FCR_ADDR_CTRL4, 32'h1);
        repeat (4) @(posedge clock);
        chk({31'h0, seq_suspend}, 32'h0);
        rchk(`FCR_ADDR_CTRL4, 32'h40, 32'h0);
        wait_done();
        // mode 0: request alone must not suspend
        wr(`FCR_ADDR_CTRL1, 32'h40);
        wr(`FCR_ADDR_CTRL4, 32'h0);
        wr(`FCR_ADDR_CMD, {21'h0, 3'h4, 6'h0, `FCR_OP_ERASE});
        wr(`FCR_ADDR_CTRL4, 32'h2);
        repeat (3) @(posedge clock);
        chk({31'h0, seq_suspend}, 32'h0);
        wr(`FCR_ADDR_CTRL4, 32'h3);
        repeat (3) @(posedge clock);
        chk({31'h0, seq_suspend}, 32'h1);
        rchk(`FCR_ADDR_CTRL4, 32'h40, 32'h40);
        wr(`FCR_ADDR_CTRL4, 32'h1);
        repeat (4) @(posedge clock);
        chk({31'h0, seq_suspend}, 32'h0);
        wait_done();
        // wait states, rewrite off then on
        wr(`FCR_ADDR_CTRL0, 32'h0);
        wr(`FCR_ADDR_MISC, 32'h1);
        wr(`FCR_ADDR_CTRL1, 32'h80);
        acc(FCR_BLK_A, 1'b1, 1'b1);
        acc(FCR_BLK_2, 1'b1, 1'b1);
        wr(`FCR_ADDR_MISC, 32'h0);
        acc(FCR_BLK_B, 1'b1, 1'b1);
        acc(FCR_BLK_2, 1'b1, 1'b0);
        acc(FCR_BLK_0, 1'b0, 1'b0);
        wr(`FCR_ADDR_CTRL1, 32'h0);
        acc(FCR_BLK_A, 1'b1, 1'b0);
        wr(`FCR_ADDR_CTRL0, 32'h2);
        acc(FCR_BLK_3, 1'b1, 1'b1);
        acc(FCR_BLK_1, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule // test_flash_cpu_rewrite_control
`default_nettype wire

// ===== logic/fcr_defines.svh
// Summary of operation
// - program and block erase are carried out only inside the user ROM area.
// - during erase suspend, program reads of user ROM are allowed.
// - one wait state on processor flash accesses while rewrite control is enabled.
// - mode-one select enters erase-write mode 1, effective only with rewrite enable.
// - user-block unlock sets only after a write of 0 followed by 1.
// - user-block unlock has no effect unless rewrite enable is 1.
// - blocks 0 and 1 rewritable only with low-block and user-block unlock set.
// - blocks 2 to 4 rewritable whenever user-block unlock is set.
// - data-block wait bit forces exactly one wait on blocks A and B.
// - other blocks and RAM follow the general wait bit; flash always waits while rewrite is enabled.
// - erase suspend is permitted only while suspend enable is 1.
// - mode 0: software suspend request during auto erase enters suspend.
// - mode 1: enabled interrupt during erase sets suspend request and suspends.
// - clearing suspend request resumes the suspended erase.
// - suspend status is 0 during auto erase, 1 in suspend.
// - after program or erase: mode 0 read-status, mode 1 read-array.
// - mode 1 holds the processor during auto write and erase.
// - mode 1 rejects read-status and commands to the control program block.
// - mode 0 status in control register 0 bits and read-status bits.
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH
`define FCR_ADDR_CTRL0   8'h00
`define FCR_ADDR_CTRL1   8'h04
`define FCR_ADDR_CTRL4   8'h08
`define FCR_ADDR_CMD     8'h0c
`define FCR_ADDR_SEQSTAT 8'h10
`define FCR_ADDR_MISC    8'h14
// control register 0 fields
`define FCR_C0_READY     0
`define FCR_C0_REWR_EN   1
`define FCR_C0_LOW_UNLK  2
`define FCR_C0_PROG_ERR  6
`define FCR_C0_ERASE_ERR 7
// control register 1 fields
`define FCR_C1_MODE1     1
`define FCR_C1_USER_UNLK 6
`define FCR_C1_DATA_WAIT 7
// control register 4 fields
`define FCR_C4_SUSP_EN   0
`define FCR_C4_SUSP_REQ  1
`define FCR_C4_SUSP_STAT 6
// sequencer status fields
`define FCR_SR_PROG      4
`define FCR_SR_ERASE     5
`define FCR_SR_READY     7
// misc register fields
`define FCR_MS_GEN_WAIT  0
`define FCR_MS_READ_STAT 1
`define FCR_MS_REJECT    2
// command word layout: [1:0] op, [10:8] block
`define FCR_OP_PROGRAM   2'h1
`define FCR_OP_ERASE     2'h2
`define FCR_OP_READ_STAT 2'h3
`endif

// ===== logic/fcr_flash_cpu_rewrite_control.sv
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"
module fcr_flash_cpu_rewrite_control (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output var  logic [31:0]          hrdata,
    output var  logic                 hreadyout,
    output var  logic                 hresp,
    // flash sequencer
    output var  logic                 seq_start,
    output var  logic [1:0]           seq_op,
    output var  fcr_pkg::fcr_block_t  seq_block,
    output var  logic                 seq_suspend,
    input  wire logic                 seq_done,
    input  wire logic                 seq_prog_fail,
    input  wire logic                 seq_erase_fail,
    // processor side
    input  wire logic                 irq_pending,
    input  wire logic                 cpu_access,
    input  wire fcr_pkg::fcr_block_t  cpu_block,
    input  wire logic                 cpu_is_flash,
    output var  logic                 cpu_wait,
    output var  logic                 cpu_hold,
    output var  logic                 flash_read_allow,
    output var  logic                 read_status_mode
);
    import fcr_pkg::*;

    fcr_state_t state;
    logic       cpu_rewrite_enable;
    logic       low_block_unlock;
    logic       erase_write_mode_one_select;
    logic       user_block_unlock;
    logic       unlock_armed;
    logic       data_block_wait_select;
    logic       erase_suspend_enable;
    logic       erase_suspend_request;
    logic       general_wait_select;
    logic       program_status_flag;
    logic       erase_status_flag;
    logic       cmd_rejected;
    logic [2:0] ctrl_block;
    logic       irq_s1;
    logic       irq_s2;
    logic       ap_valid;
    logic       ap_write;
    logic [7:0] ap_addr;

    logic       mode1;
    logic       is_erase_busy;
    logic       cmd_write;
    logic       blk_ok;
    logic       op_ok;
    logic       soft_susp;
    logic       auto_susp;
    logic       next_wait;
    fcr_block_t cmd_blk;
    logic [1:0] cmd_op;

    // mode 1 only counts while rewrite is enabled
    assign mode1 = erase_write_mode_one_select & cpu_rewrite_enable;
    assign is_erase_busy = (state == FCR_BUSY) && (seq_op == `FCR_OP_ERASE);
    assign cmd_write = ap_valid & ap_write & (ap_addr == `FCR_ADDR_CMD);
    assign cmd_op = hwdata[1:0];
    assign cmd_blk = fcr_block_t'(hwdata[10:8]);

    // block protection from the two unlock bits
    always_comb begin
        blk_ok = 1'b0;
        case (cmd_blk)
            FCR_BLK_0, FCR_BLK_1: blk_ok = low_block_unlock & user_block_unlock;
            FCR_BLK_2, FCR_BLK_3,
            FCR_BLK_4: blk_ok = user_block_unlock;
            FCR_BLK_A, FCR_BLK_B: blk_ok = 1'b1;
            default: blk_ok = 1'b0;  // outside user rom
        endcase
    end

    assign op_ok = cpu_rewrite_enable && (state == FCR_IDLE) && blk_ok
                 && ((cmd_op == `FCR_OP_PROGRAM) || (cmd_op == `FCR_OP_ERASE))
                 && !(mode1 && (hwdata[10:8] == ctrl_block));

    assign soft_susp = !mode1 && erase_suspend_enable && erase_suspend_request;
    assign auto_susp = mode1 && erase_suspend_enable && irq_s2;

    // interrupt request is asynchronous to this logic
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
        end else begin
            irq_s1 <= irq_pending;
            irq_s2 <= irq_s1;
        end
    end

    // ahb address phase capture, zero wait slave
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end else if (hready) begin
            ap_valid <= hsel & htrans[1];
            ap_write <= hwrite;
            ap_addr  <= haddr;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // control register 0
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_rewrite_enable <= 1'b0;
            low_block_unlock   <= 1'b0;
        end else if (ap_valid && ap_write && ap_addr == `FCR_ADDR_CTRL0) begin
            cpu_rewrite_enable <= hwdata[`FCR_C0_REWR_EN];
            low_block_unlock   <= hwdata[`FCR_C0_LOW_UNLK];
        end
    end

    // control register 1, unlock needs a 0 then a 1 with rewrite enabled
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            erase_write_mode_one_select <= 1'b0;
            user_block_unlock           <= 1'b0;
            unlock_armed                <= 1'b0;
            data_block_wait_select      <= 1'b0;
        end else begin
            if (!cpu_rewrite_enable) begin
                user_block_unlock <= 1'b0;
                unlock_armed      <= 1'b0;
            end else if (ap_valid && ap_write && ap_addr == `FCR_ADDR_CTRL1) begin
                if (!hwdata[`FCR_C1_USER_UNLK]) begin
                    user_block_unlock <= 1'b0;
                    unlock_armed      <= 1'b1;
                end else if (unlock_armed) begin
                    user_block_unlock <= 1'b1;
                end
            end
            if (ap_valid && ap_write && ap_addr == `FCR_ADDR_CTRL1) begin
                erase_write_mode_one_select <= hwdata[`FCR_C1_MODE1];
                data_block_wait_select      <= hwdata[`FCR_C1_DATA_WAIT];
            end
        end
    end

    // control register 4 and misc
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            erase_suspend_enable  <= 1'b0;
            erase_suspend_request <= 1'b0;
            general_wait_select   <= 1'b0;
        end else begin
            if (ap_valid && ap_write && ap_addr == `FCR_ADDR_CTRL4) begin
                erase_suspend_enable  <= hwdata[`FCR_C4_SUSP_EN];
                erase_suspend_request <= hwdata[`FCR_C4_SUSP_REQ];
            end
            // hardware set wins over a software clear in the same cycle
            if (auto_susp && is_erase_busy) begin
                erase_suspend_request <= 1'b1;
            end
            if (state == FCR_IDLE && !(ap_valid && ap_write && ap_addr == `FCR_ADDR_CTRL4)) begin
                erase_suspend_request <= 1'b0;
            end
            if (ap_valid && ap_write && ap_addr == `FCR_ADDR_MISC) begin
                general_wait_select <= hwdata[`FCR_MS_GEN_WAIT];
            end
        end
    end

    // block holding the rewrite program, set with the misc register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_block <= 3'h0;
        end else if (ap_valid && ap_write && ap_addr == `FCR_ADDR_MISC) begin
            ctrl_block <= hwdata[10:8];
        end
    end

    // sequencer control
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state       <= FCR_IDLE;
            seq_start   <= 1'b0;
            seq_op      <= 2'h0;
            seq_block   <= FCR_BLK_0;
            seq_suspend <= 1'b0;
        end else begin
            seq_start <= 1'b0;
            case (state)
                FCR_IDLE: begin
                    if (cmd_write && op_ok) begin
                        state     <= FCR_BUSY;
                        seq_start <= 1'b1;
                        seq_op    <= cmd_op;
                        seq_block <= cmd_blk;
                    end
                end
                FCR_BUSY: begin
                    if (seq_done) begin
                        state <= FCR_IDLE;
                    end else if (is_erase_busy && (soft_susp || auto_susp)) begin
                        state       <= FCR_SUSPEND;
                        seq_suspend <= 1'b1;
                    end
                end
                FCR_SUSPEND: begin
                    if (!erase_suspend_request && !auto_susp) begin
                        state       <= FCR_RESUME;
                        seq_suspend <= 1'b0;
                    end
                end
                FCR_RESUME: begin
                    state <= FCR_BUSY;
                end
                default: begin
                    state <= FCR_IDLE;
                end
            endcase
        end
    end

    // result flags and mode after completion
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            program_status_flag <= 1'b0;
            erase_status_flag   <= 1'b0;
            read_status_mode    <= 1'b0;
            cmd_rejected        <= 1'b0;
        end else begin
            if (state == FCR_BUSY && seq_done) begin
                program_status_flag <= (seq_op == `FCR_OP_PROGRAM) & seq_prog_fail;
                erase_status_flag   <= (seq_op == `FCR_OP_ERASE) & seq_erase_fail;
                read_status_mode    <= !mode1;
            end else if (cmd_write && cmd_op == `FCR_OP_READ_STAT && !mode1) begin
                read_status_mode <= 1'b1;
            end
            if (cmd_write) begin
                cmd_rejected <= (cmd_op == `FCR_OP_READ_STAT) ? mode1 : !op_ok;
            end
        end
    end

    // processor side: wait, hold, read permission
    always_comb begin
        next_wait = 1'b0;
        if (cpu_access) begin
            if (cpu_is_flash && (cpu_block == FCR_BLK_A || cpu_block == FCR_BLK_B)) begin
                next_wait = data_block_wait_select ? 1'b1 : general_wait_select;
            end else begin
                next_wait = general_wait_select;
            end
            if (cpu_is_flash && cpu_rewrite_enable) begin
                next_wait = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_wait         <= 1'b0;
            cpu_hold         <= 1'b0;
            flash_read_allow <= 1'b1;
        end else begin
            cpu_wait         <= next_wait;
            cpu_hold         <= mode1 && (state == FCR_BUSY || state == FCR_RESUME);
            flash_read_allow <= (state == FCR_IDLE) || (state == FCR_SUSPEND);
        end
    end

    // register read data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && htrans[1] && !hwrite && hready) begin
            hrdata <= 32'h0000_0000;
            case (haddr)
                `FCR_ADDR_CTRL0: begin
                    hrdata[`FCR_C0_READY]     <= (state == FCR_IDLE);
                    hrdata[`FCR_C0_REWR_EN]   <= cpu_rewrite_enable;
                    hrdata[`FCR_C0_LOW_UNLK]  <= low_block_unlock;
                    hrdata[`FCR_C0_PROG_ERR]  <= program_status_flag;
                    hrdata[`FCR_C0_ERASE_ERR] <= erase_status_flag;
                end
                `FCR_ADDR_CTRL1: begin
                    hrdata[`FCR_C1_MODE1]     <= erase_write_mode_one_select;
                    hrdata[`FCR_C1_USER_UNLK] <= user_block_unlock;
                    hrdata[`FCR_C1_DATA_WAIT] <= data_block_wait_select;
                end
                `FCR_ADDR_CTRL4: begin
                    hrdata[`FCR_C4_SUSP_EN]   <= erase_suspend_enable;
                    hrdata[`FCR_C4_SUSP_REQ]  <= erase_suspend_request;
                    hrdata[`FCR_C4_SUSP_STAT] <= (state == FCR_SUSPEND);
                end
                `FCR_ADDR_SEQSTAT: begin
                    hrdata[`FCR_SR_READY] <= (state == FCR_IDLE);
                    hrdata[`FCR_SR_ERASE] <= erase_status_flag;
                    hrdata[`FCR_SR_PROG]  <= program_status_flag;
                end
                `FCR_ADDR_MISC: begin
                    hrdata[`FCR_MS_GEN_WAIT]  <= general_wait_select;
                    hrdata[`FCR_MS_READ_STAT] <= read_status_mode;
                    hrdata[`FCR_MS_REJECT]    <= cmd_rejected;
                    hrdata[10:8]              <= ctrl_block;
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule // fcr_flash_cpu_rewrite_control
`default_nettype wire

// ===== logic/fcr_pkg.sv
package fcr_pkg;
    typedef enum logic [3:0] {
        FCR_IDLE    = 4'b0001,
        FCR_BUSY    = 4'b0010,
        FCR_SUSPEND = 4'b0100,
        FCR_RESUME  = 4'b1000
    } fcr_state_t;
    typedef enum logic [2:0] {
        FCR_BLK_0 = 3'h0,
        FCR_BLK_1 = 3'h1,
        FCR_BLK_2 = 3'h2,
        FCR_BLK_3 = 3'h3,
        FCR_BLK_4 = 3'h4,
        FCR_BLK_A = 3'h5,
        FCR_BLK_B = 3'h6,
        FCR_BLK_X = 3'h7
    } fcr_block_t;
endpackage
